/* shared/ahr_pkg.sv */
// Constants and types shared by the converter read-out host
package ahr_pkg;
  // ----------------------------------------------------------------
  // Clock and word format
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int CHAIN_W = 2;
  localparam int CNT_W = 16;
  localparam int BIT_W = 5;

  // ----------------------------------------------------------------
  // Timing, each time in ns with its cycle count derived
  // ----------------------------------------------------------------
  localparam int T_CNV_LOW_NS = 40;
  localparam int CNV_LOW_CYC = (T_CNV_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int T_SAMPLE_NS = 10000;
  localparam int SAMPLE_CYC = (T_SAMPLE_NS * CLK_MHZ) / 1000;
  localparam int T_SCLK_HALF_NS = 100;
  localparam int SCLK_HALF_CYC = (T_SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int T_BYTE_GAP_NS = 100;
  localparam int BYTE_GAP_CYC = (T_BYTE_GAP_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // Serial port states of the microcontroller-style reader
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AHR_IDLE,
    AHR_LOW,
    AHR_HIGH,
    AHR_GAP
  } ahr_spi_state_type;
endpackage

/* shared/ahr_stream_if.sv */
// Word stream carrier between the reader and its buffer
`timescale 1ns/10ps
`default_nettype none
interface ahr_stream_if;
  logic valid;
  logic ready;
  logic [ahr_pkg::WORD_BITS-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* logic/ahr_buf.sv */
// Two-entry word buffer with registered outputs
`timescale 1ns/10ps
`default_nettype none
module ahr_buf (
  input wire logic clk,
  input wire logic reset,
  ahr_stream_if.snk in_s,
  ahr_stream_if.src out_s
);
  logic head_v_q;
  logic spare_v_q;
  logic [ahr_pkg::WORD_BITS-1:0] head_q;
  logic [ahr_pkg::WORD_BITS-1:0] spare_q;
  logic push;
  logic pop;

  // Ready only needs the spare slot, so it is a plain register read
  assign in_s.ready = ~spare_v_q;
  assign out_s.valid = head_v_q;
  assign out_s.data = head_q;
  assign push = in_s.valid & ~spare_v_q;
  assign pop = head_v_q & out_s.ready;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      head_v_q <= 1'b0;
      spare_v_q <= 1'b0;
      head_q <= '0;
      spare_q <= '0;
    end else if (!head_v_q || pop) begin
      if (spare_v_q) begin
        head_q <= spare_q;
        head_v_q <= 1'b1;
        spare_v_q <= 1'b0;
      end else begin
        head_q <= in_s.data;
        head_v_q <= push;
      end
    end else if (push) begin
      spare_q <= in_s.data;
      spare_v_q <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* logic/ahr_host.sv */
// Host controller that starts conversions and reads results from the converter
`timescale 1ns/10ps
`default_nettype none
module ahr_host (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_clk,
  input wire logic mode_dsp,
  input wire logic run,
  input wire logic [ahr_pkg::CHAIN_W-1:0] chain_len,
  input wire logic busy,
  input wire logic serial_data_out,
  input wire logic link_frame,
  output logic convert_start_n,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic [ahr_pkg::WORD_BITS-1:0] word_data,
  output logic word_valid,
  input wire logic word_ready,
  output logic overrun,
  output logic link_aligned
);
  // ----------------------------------------------------------------
  // Link domain: converter-clocked receiver
  // ----------------------------------------------------------------
  logic [ahr_pkg::WORD_BITS-1:0] lk_shift_q;
  logic [ahr_pkg::WORD_BITS-1:0] lk_word_q;
  logic [ahr_pkg::BIT_W-1:0] lk_cnt_q;
  logic lk_tog_q;
  logic lk_first_q;
  logic [ahr_pkg::WORD_BITS-1:0] lk_next;

  assign lk_next = {lk_shift_q[ahr_pkg::WORD_BITS-2:0], serial_data_out};

  // Clock and frame come from the converter; data sampled on rising edge
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      lk_shift_q <= '0;
      lk_cnt_q <= '0;
    end else if (link_frame) begin
      lk_shift_q <= lk_next;
      if (lk_cnt_q == ahr_pkg::BIT_W'(ahr_pkg::WORD_BITS - 1)) begin
        lk_cnt_q <= '0;
      end else begin
        lk_cnt_q <= lk_cnt_q + 1'b1;
      end
    end else begin
      lk_cnt_q <= '0;
    end
  end

  // Word hand-off; the held word is stable for a whole frame after a toggle
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      lk_word_q <= '0;
      lk_tog_q <= 1'b0;
      lk_first_q <= 1'b1;
    end else if (link_frame
                 && lk_cnt_q == ahr_pkg::BIT_W'(ahr_pkg::WORD_BITS - 1)) begin
      if (lk_first_q) begin
        lk_first_q <= 1'b0;
      end else begin
        lk_word_q <= lk_next;
        lk_tog_q <= ~lk_tog_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Crossings and pin synchronisers
  // ----------------------------------------------------------------
  logic tog_s1_q;
  logic tog_s2_q;
  logic tog_s3_q;
  logic first_s1_q;
  logic first_s2_q;
  logic busy_s1_q;
  logic busy_s2_q;
  logic busy_s3_q;
  logic sdo_s1_q;
  logic sdo_s2_q;
  logic lk_event;
  logic busy_fall;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tog_s1_q <= 1'b0;
      tog_s2_q <= 1'b0;
      tog_s3_q <= 1'b0;
      first_s1_q <= 1'b1;
      first_s2_q <= 1'b1;
    end else begin
      tog_s1_q <= lk_tog_q;
      tog_s2_q <= tog_s1_q;
      tog_s3_q <= tog_s2_q;
      first_s1_q <= lk_first_q;
      first_s2_q <= first_s1_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_s1_q <= 1'b0;
      busy_s2_q <= 1'b0;
      busy_s3_q <= 1'b0;
      sdo_s1_q <= 1'b0;
      sdo_s2_q <= 1'b0;
    end else begin
      busy_s1_q <= busy;
      busy_s2_q <= busy_s1_q;
      busy_s3_q <= busy_s2_q;
      sdo_s1_q <= serial_data_out;
      sdo_s2_q <= sdo_s1_q;
    end
  end

  assign lk_event = tog_s2_q ^ tog_s3_q;
  // Edge only: a busy line left low never retriggers a read
  assign busy_fall = busy_s3_q & ~busy_s2_q;

  // ----------------------------------------------------------------
  // Sample timer and conversion start
  // ----------------------------------------------------------------
  ahr_pkg::ahr_spi_state_type state_q;
  logic pending_q;
  logic [ahr_pkg::CNT_W-1:0] tmr_q;
  logic [ahr_pkg::CNT_W-1:0] cnv_q;
  logic slave_busy;

  // While a slave read is due or running the timer waits, so no new
  // conversion can start under the read; each period then grows by the time the read is due or running
  assign slave_busy = ~mode_dsp & (pending_q | (state_q != ahr_pkg::AHR_IDLE));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tmr_q <= '0;
      cnv_q <= '0;
      convert_start_n <= 1'b1;
    end else begin
      if (cnv_q != '0) begin
        cnv_q <= cnv_q - 1'b1;
        // Timer keeps counting under the pulse so starts stay a full period apart
        tmr_q <= tmr_q - 1'b1;
        convert_start_n <= (cnv_q == ahr_pkg::CNT_W'(1));
      end else if (!run || slave_busy) begin
        convert_start_n <= 1'b1;
      end else if (tmr_q == '0) begin
        tmr_q <= ahr_pkg::CNT_W'(ahr_pkg::SAMPLE_CYC - 1);
        cnv_q <= ahr_pkg::CNT_W'(ahr_pkg::CNV_LOW_CYC);
        convert_start_n <= 1'b0;
      end else begin
        tmr_q <= tmr_q - 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave read after conversion, byte by byte
  // ----------------------------------------------------------------
  logic [ahr_pkg::CNT_W-1:0] phase_q;
  logic [ahr_pkg::BIT_W-1:0] bit_q;
  logic [ahr_pkg::CHAIN_W-1:0] widx_q;
  logic [ahr_pkg::WORD_BITS-1:0] spi_shift_q;
  logic spi_push_q;
  logic buf_room;
  logic phase_end;

  assign phase_end = (phase_q == '0);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending_q <= 1'b0;
    end else if (busy_fall && !mode_dsp) begin
      pending_q <= 1'b1;
    end else if (state_q == ahr_pkg::AHR_IDLE && buf_room) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ahr_pkg::AHR_IDLE;
      phase_q <= '0;
      bit_q <= '0;
      widx_q <= '0;
      spi_shift_q <= '0;
      spi_push_q <= 1'b0;
      spi_sclk <= 1'b0;
      spi_cs_n <= 1'b1;
    end else begin
      spi_push_q <= 1'b0;
      unique case (state_q)
        ahr_pkg::AHR_IDLE: begin
          spi_sclk <= 1'b0;
          if (pending_q && buf_room) begin
            spi_cs_n <= 1'b0;
            bit_q <= '0;
            widx_q <= '0;
            phase_q <= ahr_pkg::CNT_W'(ahr_pkg::SCLK_HALF_CYC - 1);
            state_q <= ahr_pkg::AHR_LOW;
          end
        end
        ahr_pkg::AHR_LOW: begin
          if (phase_end) begin
            spi_sclk <= 1'b1;
            phase_q <= ahr_pkg::CNT_W'(ahr_pkg::SCLK_HALF_CYC - 1);
            state_q <= ahr_pkg::AHR_HIGH;
          end else begin
            phase_q <= phase_q - 1'b1;
          end
        end
        ahr_pkg::AHR_HIGH: begin
          if (phase_end) begin
            // Trailing edge takes the bit, most significant first
            spi_sclk <= 1'b0;
            spi_shift_q <= {spi_shift_q[ahr_pkg::WORD_BITS-2:0], sdo_s2_q};
            bit_q <= bit_q + 1'b1;
            if (bit_q == ahr_pkg::BIT_W'(ahr_pkg::WORD_BITS - 1)) begin
              spi_push_q <= 1'b1;
            end
            if (bit_q == ahr_pkg::BIT_W'(ahr_pkg::BYTE_BITS - 1)
                || bit_q == ahr_pkg::BIT_W'(ahr_pkg::WORD_BITS - 1)) begin
              phase_q <= ahr_pkg::CNT_W'(ahr_pkg::BYTE_GAP_CYC - 1);
              state_q <= ahr_pkg::AHR_GAP;
            end else begin
              phase_q <= ahr_pkg::CNT_W'(ahr_pkg::SCLK_HALF_CYC - 1);
              state_q <= ahr_pkg::AHR_LOW;
            end
          end else begin
            phase_q <= phase_q - 1'b1;
          end
        end
        ahr_pkg::AHR_GAP: begin
          if (!phase_end) begin
            phase_q <= phase_q - 1'b1;
          end else if (bit_q != ahr_pkg::BIT_W'(ahr_pkg::WORD_BITS)) begin
            phase_q <= ahr_pkg::CNT_W'(ahr_pkg::SCLK_HALF_CYC - 1);
            state_q <= ahr_pkg::AHR_LOW;
          end else if (widx_q == chain_len) begin
            spi_cs_n <= 1'b1;
            state_q <= ahr_pkg::AHR_IDLE;
          end else if (buf_room && !spi_push_q) begin
            // Next cascaded result follows on the same select
            widx_q <= widx_q + 1'b1;
            bit_q <= '0;
            phase_q <= ahr_pkg::CNT_W'(ahr_pkg::SCLK_HALF_CYC - 1);
            state_q <= ahr_pkg::AHR_LOW;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Word merge into the buffer
  // ----------------------------------------------------------------
  ahr_stream_if fill_s ();
  ahr_stream_if drain_s ();
  logic lk_push_q;
  logic [ahr_pkg::WORD_BITS-1:0] lk_data_q;

  assign buf_room = fill_s.ready;

  // The converter cannot be stalled when it clocks; a full buffer drops it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lk_push_q <= 1'b0;
      lk_data_q <= '0;
      overrun <= 1'b0;
    end else begin
      lk_push_q <= lk_event & mode_dsp & fill_s.ready;
      overrun <= lk_event & mode_dsp & ~fill_s.ready;
      if (lk_event) begin
        lk_data_q <= lk_word_q;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      link_aligned <= 1'b0;
    end else begin
      link_aligned <= ~first_s2_q;
    end
  end

  assign fill_s.valid = spi_push_q | lk_push_q;
  assign fill_s.data = spi_push_q ? spi_shift_q : lk_data_q;

  ahr_buf u_buf (
    .clk(clk),
    .reset(reset),
    .in_s(fill_s.snk),
    .out_s(drain_s.src)
  );

  assign drain_s.ready = word_ready;
  assign word_valid = drain_s.valid;
  assign word_data = drain_s.data;
endmodule
`default_nettype wire

/* bench/ahr_host_props.sv */
// Port checks for the converter read-out host
`timescale 1ns/10ps
`default_nettype none
module ahr_host_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic mode_dsp,
  input wire logic run,
  input wire logic word_ready,
  input wire logic convert_start_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic [ahr_pkg::WORD_BITS-1:0] word_data,
  input wire logic word_valid,
  input wire logic overrun,
  input wire logic link_aligned
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic cnv_q;
  logic seen_q;
  logic [15:0] gap_q;
  // Start spacing is only trusted while run has stayed high since the last start
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnv_q <= 1'b1;
      seen_q <= 1'b0;
      gap_q <= 16'h0;
    end else begin
      cnv_q <= convert_start_n;
      seen_q <= run & (seen_q | (cnv_q & ~convert_start_n));
      gap_q <= (cnv_q & ~convert_start_n) ? 16'h1 : gap_q + 16'h1;
    end
  end
  cnv_width_a: assert property ($fell(convert_start_n) |->
    !convert_start_n [*2] ##1 convert_start_n) else $error("start pulse width");
  cnv_period_a: assert property (seen_q && mode_dsp && cnv_q && !convert_start_n |->
    gap_q == 16'(ahr_pkg::SAMPLE_CYC)) else $error("start period");
  first_clk_a: assert property ($fell(spi_cs_n) |-> !spi_sclk [*4] ##1 spi_sclk)
    else $error("select to clock delay");
  sclk_high_a: assert property ($rose(spi_sclk) |-> spi_sclk [*4] ##1 !spi_sclk)
    else $error("clock high time");
  idle_low_a: assert property (spi_cs_n |-> !spi_sclk) else $error("clock idle level");
  read_quiet_a: assert property (!mode_dsp && !spi_cs_n |-> convert_start_n)
    else $error("start during read");
  word_hold_a: assert property (word_valid && !word_ready |=>
    word_valid && $stable(word_data)) else $error("stalled word changed");
  drop_full_a: assert property (overrun |-> word_valid && mode_dsp)
    else $error("drop without full buffer");
  aligned_hold_a: assert property (link_aligned |=> link_aligned) else $error("alignment lost");
  ovr_pulse_a: assert property (overrun |=> !overrun) else $error("overrun too long");
endmodule
bind ahr_host ahr_host_props u_props (.clk(clk), .reset(reset), .mode_dsp(mode_dsp),
  .run(run), .word_ready(word_ready), .convert_start_n(convert_start_n),
  .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .word_data(word_data),
  .word_valid(word_valid), .overrun(overrun), .link_aligned(link_aligned));
`default_nettype wire

/* bench/ahr_conv_model.sv */
// Behavioural converter facing the read-out host
`timescale 1ns/10ps
`default_nettype none
module ahr_conv_model #(
  parameter int CONV_NS = 1500
) (
  input wire logic convert_start_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic mode_dsp,
  output logic busy,
  output logic serial_data_out,
  output logic link_clk,
  output logic link_frame
);
  logic [63:0] sh = 64'h0;
  int cnt = 0;
  int idx = 0;
  initial begin
    busy = 1'b0;
    serial_data_out = 1'b0;
    link_clk = 1'b0;
    link_frame = 1'b0;
  end
  // Four cascaded converters sampled together; the nearest one leads the stream
  always @(negedge convert_start_n) begin
    busy = 1'b1;
    for (int j = 0; j < 4; j++) sh = {sh[47:0], 16'ha55a ^ {cnt[7:0], 8'h00} ^ 16'(j)};
    cnt++;
    #(CONV_NS) busy = 1'b0;
    if (mode_dsp) begin
      for (int i = 0; i < 16; i++) begin
        link_frame = 1'b1;
        serial_data_out = sh[63-i];
        #24 link_clk = 1'b1;
        #24 link_clk = 1'b0;
      end
      link_frame = 1'b0;
      serial_data_out = ~serial_data_out;
    end
  end
  // Bits move on the rising clock so the host takes them on the falling one
  always @(negedge spi_cs_n) idx = 0;
  always @(posedge spi_sclk) begin
    if (!spi_cs_n) begin
      serial_data_out = sh[63-idx];
      idx++;
    end
  end
  // Released line must not keep looking valid
  always @(posedge spi_cs_n) serial_data_out = ~serial_data_out;
endmodule
`default_nettype wire

/* bench/ahr_host_tb.sv */
// Self-checking bench for the converter read-out host
`timescale 1ns/10ps
`default_nettype none
module ahr_host_tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic mode_dsp = 1'b0;
  logic run = 1'b0;
  logic word_ready = 1'b0;
  logic [1:0] chain_len = 2'h0;
  logic link_clk, busy, serial_data_out, link_frame, convert_start_n, spi_sclk, spi_cs_n;
  logic word_valid, overrun, link_aligned, al_q, cnv_q;
  logic [15:0] word_data;
  logic [15:0] expq[$];
  int error_cnt = 0;
  int n_checks = 0;
  int n_words = 0;
  int n_ovr = 0;
  int conv_n = 0;
  int cyc = 0;
  int fall_at = 0;
  int gap = 0;
  always #12.5 clk = ~clk;
  ahr_host DUT (.clk(clk), .reset(reset), .link_clk(link_clk), .mode_dsp(mode_dsp),
    .run(run), .chain_len(chain_len), .busy(busy), .serial_data_out(serial_data_out),
    .link_frame(link_frame), .convert_start_n(convert_start_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .word_data(word_data), .word_valid(word_valid),
    .word_ready(word_ready), .overrun(overrun), .link_aligned(link_aligned));
  ahr_conv_model conv (.convert_start_n(convert_start_n), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .mode_dsp(mode_dsp), .busy(busy),
    .serial_data_out(serial_data_out), .link_clk(link_clk), .link_frame(link_frame));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Expected words are queued as each conversion ends
  always @(posedge busy) conv_n++;
  always @(negedge busy) begin
    int j;
    j = 0;
    repeat (mode_dsp ? 1 : chain_len + 1) begin
      expq.push_back(16'ha55a ^ {conv_n[7:0] - 8'h01, 8'h00} ^ 16'(j));
      j++;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    cnv_q <= convert_start_n;
    al_q <= link_aligned;
    if (cnv_q === 1'b1 && convert_start_n === 1'b0) begin
      gap <= cyc - fall_at;
      fall_at <= cyc;
    end
    if (overrun === 1'b1) begin
      n_ovr++;
      void'(expq.pop_back());
    end
    if (link_aligned === 1'b1 && al_q !== 1'b1) void'(expq.pop_front());
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      n_words++;
      check(word_data, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
    end
  end
  task automatic reset_dut(input logic m, input logic [1:0] c);
    @(posedge clk);
    run <= 1'b0;
    if (reset !== 1'b1) repeat (900) @(posedge clk);
    mode_dsp <= m;
    chain_len <= c;
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    expq.delete();
    reset <= 1'b0;
    @(posedge clk);
    #1;
    check(16'({convert_start_n, spi_sclk, spi_cs_n, word_valid, overrun}), 16'h0014);
    check(word_data ^ 16'(link_aligned), 16'h0000);
    // Hand back on a rising edge so callers drive inputs there
    @(posedge clk);
  endtask
  task automatic wait_words(input int n);
    int k;
    k = 0;
    while (n_words < n && k < 6000) begin
      @(posedge clk);
      k++;
    end
    check(16'(n_words), 16'(n));
  endtask
  // Reader stalls: a word must wait in the buffer; with chain 3 the full buffer holds the read open
  task automatic t_slave(input logic [1:0] c);
    int n0;
    reset_dut(1'b0, c);
    n0 = n_words;
    run <= 1'b1;
    word_ready <= 1'b0;
    repeat (700) @(posedge clk);
    check(16'(word_valid), 16'h0001);
    if (c == 2'h3) check(16'(spi_cs_n), 16'h0000);
    word_ready <= 1'b1;
    wait_words(n0 + 2 * (c + 1));
    run <= 1'b0;
  endtask
  task automatic t_dsp();
    int n0;
    int k;
    reset_dut(1'b1, 2'h0);
    n0 = n_words;
    word_ready <= 1'b1;
    run <= 1'b1;
    k = 0;
    while (link_aligned !== 1'b1 && k < 2000) begin
      @(posedge clk);
      k++;
    end
    check({link_aligned, 15'(n_words - n0)}, 16'h8000);
    wait_words(n0 + 2);
    check(16'(gap), 16'(ahr_pkg::SAMPLE_CYC));
    word_ready <= 1'b0;
    n0 = n_ovr;
    k = 0;
    while (n_ovr == n0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    check(16'(n_ovr - n0), 16'h0001);
    word_ready <= 1'b1;
    repeat (10) @(posedge clk);
    check(16'(word_valid), 16'h0000);
    run <= 1'b0;
  endtask
  initial begin
    t_slave(2'h0);
    t_slave(2'h3);
    t_dsp();
    report_and_stop();
  end
  // Whole run needs about 7k cycles; this leaves wide margin
  initial begin
    #1_000_000;
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
